// ==== verilog/cms_pkg.sv ====
package cms_pkg;
	typedef enum logic [2:0] {
		CMS_X16    = 3'b000,
		CMS_DIV2   = 3'b001,
		CMS_X10    = 3'b010,
		CMS_DIRECT = 3'b011,
		CMS_X5     = 3'b100,
		CMS_X8     = 3'b101,
		CMS_X3     = 3'b110,
		CMS_X4     = 3'b111
	} cms_mode_e;

	localparam cms_mode_e CMS_MODE_RST = CMS_X4;
	localparam int        CMS_AW       = 8;
	localparam int        CMS_DW       = 32;

	localparam logic [7:0] CMS_SYSCFG_OFS = 8'h00;
	localparam logic [7:0] CMS_STAT_OFS   = 8'h04;
	localparam logic [7:0] CMS_MASK_OFS   = 8'h08;
	localparam logic [7:0] CMS_MODE_OFS   = 8'h0c;

	localparam int         CMS_OWD_DIS_BIT = 4;
	localparam logic [4:0] CMS_SYSCFG_RST  = 5'h00;
	localparam int         CMS_OWD_FAIL_BIT = 0;
	localparam logic [0:0] CMS_STAT_RST    = 1'h0;
	localparam logic [0:0] CMS_MASK_RST    = 1'h0;

	localparam int         CMS_CLK_PERIOD_NS = 8;
	localparam int         CMS_OWD_CYCLES    = 16;
	localparam logic [3:0] CMS_OWD_LAST      = 4'(CMS_OWD_CYCLES - 1);

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cms_bus_req_s;

	typedef struct packed {
		logic [4:0] factor;
		logic       pll_run;
		logic       osc_amp_en;
		logic       ext_clk_ok;
	} cms_clk_cfg_s;
endpackage : cms_pkg

// ==== verilog/cms_clock_mode_select.sv ====
`timescale 1ns/100ps
// Function
// - The clock generation mode comes from three strap pins sampled around reset.
// - Strap codes 111,110,101,100,011,010,001,000 select x4,x3,x8,x5,direct,x10,div2,x16.
// - Code 001 makes the CPU clock half the input clock through a prescaler.
// - In prescaler mode each CPU clock phase lasts one full input period.
// - Code 011 bypasses the amplifier and drives the CPU clock from the crystal pin; the PLL stops only when the watchdog disable bit is set.
// - In direct drive the CPU clock follows the input duty cycle, two halves making one input period.
// - In prescaler and direct modes a clear disable bit keeps the PLL free running, a set bit stops it unless the watchdog has failed.
// - Both CPU clock edges are offered as triggers for sequencing and bus cycles.
// - Only direct drive accepts a forced clock; other modes keep the amplifier on.
// - The oscillator watchdog is enabled after reset in prescaler and direct modes only and is disabled by bit 4 of the configuration register.
// - The watchdog counts PLL cycles, clears on every crystal transition and overflows after 16.
// - On overflow the CPU clock moves to the PLL clock until reset and an interrupt is flagged until the status bit is written with one.
module cms_clock_mode_select (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_b_i,
	input  wire logic [2:0]           clock_mode_strap_bits_i,
	input  wire logic                 crystal_input_pin_i,
	input  wire cms_pkg::cms_bus_req_s bus_i,
	output logic [31:0]               rdata_o,
	output logic                      cpu_clk_o,
	output logic                      cpu_rise_o,
	output logic                      cpu_fall_o,
	output cms_pkg::cms_clk_cfg_s     clk_cfg_o,
	output logic                      owd_fail_o,
	output logic                      irq_o
);
	import cms_pkg::*;

	cms_mode_e  mode;
	logic       strap_taken;
	logic [4:0] system_config_register;
	logic [0:0] status;
	logic [0:0] mask;
	logic       xtal_q;
	logic [3:0] owd_cnt;
	logic       failed;
	logic       next_cpu_clk;
	logic       xtal_edge;
	logic       xtal_rise;
	logic       non_pll;
	logic       osc_watchdog_disable;
	logic       owd_run;
	logic       owd_over;
	logic       wr_hit_stat;
	cms_clk_cfg_s next_cfg;

	assign osc_watchdog_disable = system_config_register[CMS_OWD_DIS_BIT];
	assign xtal_edge = crystal_input_pin_i ^ xtal_q;
	assign xtal_rise = crystal_input_pin_i & ~xtal_q;
	assign non_pll   = (mode == CMS_DIRECT) || (mode == CMS_DIV2);
	assign owd_run   = strap_taken && non_pll && !osc_watchdog_disable && !failed;
	assign owd_over  = owd_run && !xtal_edge && (owd_cnt == CMS_OWD_LAST);
	assign wr_hit_stat = bus_i.wr && (bus_i.addr == CMS_STAT_OFS);

	// Strap capture
	// Reset flops take constants only, so the pins are caught on the first edge after release
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode        <= CMS_MODE_RST;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			mode        <= cms_mode_e'(clock_mode_strap_bits_i);
			strap_taken <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xtal_q <= 1'b0;
		end else begin
			xtal_q <= crystal_input_pin_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			owd_cnt <= 4'h0;
		end else if (!owd_run || xtal_edge) begin
			owd_cnt <= 4'h0;
		end else if (owd_cnt != CMS_OWD_LAST) begin
			owd_cnt <= owd_cnt + 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			failed <= 1'b0;
		end else if (owd_over) begin
			failed <= 1'b1;
		end
	end

	always_comb begin
		next_cfg = '0;
		case (mode)
			CMS_X16:    next_cfg.factor = 5'h10;
			CMS_DIV2:   next_cfg.factor = 5'h00;
			CMS_X10:    next_cfg.factor = 5'h0a;
			CMS_DIRECT: next_cfg.factor = 5'h01;
			CMS_X5:     next_cfg.factor = 5'h05;
			CMS_X8:     next_cfg.factor = 5'h08;
			CMS_X3:     next_cfg.factor = 5'h03;
			CMS_X4:     next_cfg.factor = 5'h04;
			default:    next_cfg.factor = 5'h04;
		endcase
		next_cfg.pll_run    = !non_pll || !osc_watchdog_disable || failed;
		next_cfg.osc_amp_en = (mode != CMS_DIRECT);
		next_cfg.ext_clk_ok = (mode == CMS_DIRECT);
	end

	// PLL modes and the failed state use the system clock as the free-running PLL stand-in
	always_comb begin
		if (failed || !non_pll) begin
			next_cpu_clk = ~cpu_clk_o;
		end else if (mode == CMS_DIV2) begin
			next_cpu_clk = xtal_rise ? ~cpu_clk_o : cpu_clk_o;
		end else begin
			next_cpu_clk = crystal_input_pin_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cpu_clk_o  <= 1'b0;
			cpu_rise_o <= 1'b0;
			cpu_fall_o <= 1'b0;
		end else begin
			cpu_clk_o  <= next_cpu_clk;
			cpu_rise_o <= next_cpu_clk & ~cpu_clk_o;
			cpu_fall_o <= ~next_cpu_clk & cpu_clk_o;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_cfg_o  <= '0;
			owd_fail_o <= 1'b0;
		end else begin
			clk_cfg_o  <= next_cfg;
			owd_fail_o <= failed | owd_over;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			system_config_register <= CMS_SYSCFG_RST;
			mask                   <= CMS_MASK_RST;
		end else if (bus_i.wr) begin
			if (bus_i.addr == CMS_SYSCFG_OFS) begin
				system_config_register <= bus_i.wdata[4:0];
			end
			if (bus_i.addr == CMS_MASK_OFS) begin
				mask <= bus_i.wdata[0:0];
			end
		end
	end

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status <= CMS_STAT_RST;
		end else if (owd_over) begin
			status[CMS_OWD_FAIL_BIT] <= 1'b1;
		end else if (wr_hit_stat && bus_i.wdata[CMS_OWD_FAIL_BIT]) begin
			status[CMS_OWD_FAIL_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status & mask);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 32'h0;
		end else if (bus_i.rd) begin
			case (bus_i.addr)
				CMS_SYSCFG_OFS: rdata_o <= {27'h0, system_config_register};
				CMS_STAT_OFS:   rdata_o <= {31'h0, status};
				CMS_MASK_OFS:   rdata_o <= {31'h0, mask};
				CMS_MODE_OFS:   rdata_o <= {27'h0, next_cfg.pll_run, failed, mode};
				default:        rdata_o <= 32'h0;
			endcase
		end else begin
			rdata_o <= 32'h0;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_no_edge16;
		(owd_run && !xtal_edge) [*8] ##1 (owd_run && !xtal_edge) [*8];
	endsequence

	strap_hold_a: assert property (strap_taken |=> $stable(mode))
		else $error("mode changed after capture");
	strap_take_a: assert property (!strap_taken |=> mode == $past(clock_mode_strap_bits_i))
		else $error("strap not captured");
	div_toggle_a: assert property (mode == CMS_DIV2 && !failed && !owd_over
		|=> cpu_clk_o == ($past(cpu_clk_o) ^ $past(xtal_rise)))
		else $error("prescaler phase wrong");
	direct_follow_a: assert property (mode == CMS_DIRECT && strap_taken && !failed && !owd_over
		|=> cpu_clk_o == $past(crystal_input_pin_i))
		else $error("direct clock not following pin");
	owd_over_a: assert property (s_no_edge16 |-> ##1 failed)
		else $error("no overflow after 16 cycles");
	fail_sticky_a: assert property (failed |=> failed && cpu_clk_o != $past(cpu_clk_o))
		else $error("failed state left or clock stalled");
	pll_off_a: assert property (non_pll && osc_watchdog_disable && !failed |=> !clk_cfg_o.pll_run)
		else $error("PLL not off");
	amp_on_a: assert property (mode != CMS_DIRECT |=> clk_cfg_o.osc_amp_en && !clk_cfg_o.ext_clk_ok)
		else $error("amplifier off outside direct");
	irq_level_a: assert property (status[0] && mask[0] |=> irq_o)
		else $error("irq missing");
	edge_pulse_a: assert property (cpu_rise_o |-> cpu_clk_o && !$past(cpu_clk_o))
		else $error("rise strobe wrong");
	fall_pulse_a: assert property (cpu_fall_o |-> !cpu_clk_o && $past(cpu_clk_o))
		else $error("fall strobe wrong");

	// One cycle after overflow the internal switch and the visible status flag are set together
	sequence s_owd_trip;
		owd_over ##1 (failed && status[CMS_OWD_FAIL_BIT]);
	endsequence

	sequence s_fail_seen;
		failed ##1 owd_fail_o;
	endsequence

	owd_trip_a: assert property (owd_over |-> s_owd_trip)
		else $error("overflow did not set failure and status");
	fail_out_a: assert property (failed |-> s_fail_seen)
		else $error("failure output not raised");

	// Any crystal transition restarts the count
	owd_clear_a: assert property (xtal_edge |=> owd_cnt == 4'h0)
		else $error("watchdog count not cleared");
	owd_dis_a: assert property (osc_watchdog_disable |-> !owd_run)
		else $error("watchdog running while disabled");

	// Multiplying modes always need the PLL
	pll_run_a: assert property (!non_pll |=> clk_cfg_o.pll_run)
		else $error("PLL off in a multiplying mode");
	pll_on_a: assert property (non_pll && !osc_watchdog_disable |=> clk_cfg_o.pll_run)
		else $error("PLL off while watchdog needs it");
	direct_amp_a: assert property (mode == CMS_DIRECT |=> !clk_cfg_o.osc_amp_en && clk_cfg_o.ext_clk_ok)
		else $error("amplifier not bypassed in direct");

	// Stand-in PLL clock toggles every cycle once the mode is settled
	pll_toggle_a: assert property (strap_taken && !non_pll |=> cpu_clk_o != $past(cpu_clk_o))
		else $error("PLL stand-in clock stalled");
	factor_a: assert property (strap_taken && mode == CMS_DIV2 |=> clk_cfg_o.factor == 5'h00)
		else $error("prescaler factor wrong");

	// Write-one clear only when no set competes
	stat_clear_a: assert property (wr_hit_stat && bus_i.wdata[CMS_OWD_FAIL_BIT] && !owd_over
		|=> !status[CMS_OWD_FAIL_BIT])
		else $error("status not cleared");
	irq_low_a: assert property (!(status[0] && mask[0]) |=> !irq_o)
		else $error("irq without unmasked status");

	// Read data stand one cycle only
	rdata_idle_a: assert property (!bus_i.rd |=> rdata_o == 32'h0)
		else $error("read data outside read cycle");
	mode_read_a: assert property (bus_i.rd && bus_i.addr == CMS_MODE_OFS
		|=> rdata_o[2:0] == $past(mode))
		else $error("mode readback wrong");
	cfg_read_a: assert property (bus_i.rd && bus_i.addr == CMS_SYSCFG_OFS
		|=> rdata_o[4:0] == $past(system_config_register))
		else $error("configuration readback wrong");

	// Default mode holds until the pins are taken
	strap_default_a: assert property (!strap_taken |-> mode == CMS_MODE_RST)
		else $error("mode not default before capture");
endmodule : cms_clock_mode_select

// ==== dv/cms_xtal_src.sv ====
`timescale 1ns/100ps
module cms_xtal_src (
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [3:0] hi_len_i,
	input  wire logic [3:0] lo_len_i,
	output logic            pin_o
);
	logic [3:0] cnt = 4'h1;
	initial pin_o = 1'b0;
	// Uneven duty cycle
	// A stalled source holds its level, like a dead crystal
	always @(posedge clk_i) begin
		if (run_i && cnt >= (pin_o ? hi_len_i : lo_len_i)) begin
			pin_o <= ~pin_o;
			cnt   <= 4'h1;
		end else if (run_i) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : cms_xtal_src

// ==== dv/tb_cms_clock_mode_select.sv ====
`timescale 1ns/100ps
module tb_cms_clock_mode_select;
	import cms_pkg::*;
	logic         sys_clk = 1'b0;
	logic         rst_b = 1'b0;
	logic         run = 1'b0;
	logic         chk_on = 1'b0;
	logic         failed_exp, seen, last_clk, prev_pin, pin, cpu_clk, rise, fall, fail, irq;
	logic [2:0]   strap = 3'h7;
	logic [2:0]   mode;
	logic [3:0]   hi = 4'h2;
	logic [3:0]   lo = 4'h2;
	logic [31:0]  seed = 32'h6befef74;
	logic [31:0]  rdata, ph_len;
	cms_bus_req_s bus = '0;
	cms_clk_cfg_s cfg;
	int           num_errors = 0;
	int           samples_checked = 0;
	logic [4:0]   fac_t [8] = '{5'h10, 5'h00, 5'h0a, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};

	cms_xtal_src i_cms_xtal_src (.clk_i(sys_clk), .run_i(run), .hi_len_i(hi), .lo_len_i(lo), .pin_o(pin));
	cms_clock_mode_select i_cms_clock_mode_select (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
		.clock_mode_strap_bits_i(strap), .crystal_input_pin_i(pin), .bus_i(bus), .rdata_o(rdata),
		.cpu_clk_o(cpu_clk), .cpu_rise_o(rise), .cpu_fall_o(fall), .clk_cfg_o(cfg), .owd_fail_o(fail), .irq_o(irq));

	always #4 sys_clk = ~sys_clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [31:0] exp_len(input logic lvl);
		if (failed_exp || mode[2] || !mode[0]) return 32'h1;
		if (mode[1]) return 32'(lvl ? hi : lo);
		return 32'(hi) + 32'(lo);
	endfunction : exp_len

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		@(negedge sys_clk);
		chk(rdata, e);
	endtask : rd

	task automatic span(input int n);
		chk_on <= 1'b1;
		repeat (n) @(posedge sys_clk);
		chk_on <= 1'b0;
	endtask : span

	task automatic do_reset(input logic [2:0] code, input logic [3:0] h, input logic [3:0] l);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		strap <= code;
		hi    <= h;
		lo    <= l;
		run   <= 1'b1;
		mode = code;
		failed_exp = 1'b0;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge sys_clk);
		// Pins wander once captured
		strap <= 3'(rnd());
		repeat (20) @(posedge sys_clk);
	endtask : do_reset

	// Reference clock model, sampled where outputs have settled
	always @(negedge sys_clk) begin
		if (chk_on) begin
			if (mode == CMS_DIRECT && !failed_exp) chk(32'(cpu_clk), 32'(prev_pin));
			chk(32'({rise, fall}), 32'({cpu_clk & ~last_clk, ~cpu_clk & last_clk}));
			if (cpu_clk !== last_clk) begin
				if (seen) chk(ph_len, exp_len(last_clk));
				seen = 1'b1;
				ph_len = 32'h1;
			end else ph_len++;
		end else seen = 1'b0;
		last_clk = cpu_clk;
		prev_pin = pin;
	end

	initial begin
		#100us;
		num_errors++;
		close_out();
	end

	initial begin
		for (int c = 0; c < 8; c++) begin
			do_reset(3'(c), 4'(rnd() % 7 + 1), 4'(rnd() % 7 + 1));
			rd(CMS_MODE_OFS, {27'h0, 1'b1, 1'b0, mode});
			chk(32'(cfg), {24'h0, fac_t[c], 1'b1, mode != CMS_DIRECT, mode == CMS_DIRECT});
			span(60);
		end
		do_reset(3'h3, 4'h3, 4'h5);
		wr(CMS_SYSCFG_OFS, 32'h10);
		rd(CMS_SYSCFG_OFS, 32'h10);
		@(posedge sys_clk);
		run <= 1'b0;
		repeat (40) @(posedge sys_clk);
		chk(32'({cfg.pll_run, fail}), 32'h0);
		for (int m = 0; m < 2; m++) begin
			do_reset(m ? 3'h1 : 3'h3, 4'hf, 4'hf);
			wr(CMS_MASK_OFS, 32'(1 - m));
			span(150);
			chk(32'(fail), 32'h0);
			@(posedge sys_clk);
			run <= 1'b0;
			for (int i = 0; i < 40 && fail !== 1'b1; i++) @(negedge sys_clk);
			failed_exp = 1'b1;
			// Interrupt follows the status bit one cycle later
			@(negedge sys_clk);
			chk(32'({fail, irq}), {30'h0, 1'b1, m == 0});
			rd(CMS_STAT_OFS, 32'h1);
			wr(CMS_STAT_OFS, 32'h1);
			rd(CMS_MODE_OFS, {27'h0, 2'h3, mode});
			chk(32'({fail, irq}), 32'h2);
			@(posedge sys_clk);
			run <= 1'b1;
			span(40);
		end
		wr(8'h10, rnd());
		rd(8'h10, 32'h0);
		close_out();
	end
endmodule : tb_cms_clock_mode_select
